// *** rtl/prot_recovery.v ***
// protection recovery, retry latch and charge temperature protections,
// with an AXI4-Lite register slave and one level interrupt
// assumes fault inputs and measurements are synchronous to aclk
//
// Functional notes
// - retry limit code sits in bits 2..0 of the retry limit register; code 0 never latches.
// - codes 1..7 allow 2,4,8,16,32,48,96 recoveries, after which a new trip latches fets off.
// - the shared retry counter clears when no current fault retriggers 5 s after a recovery.
// - a tripped current protection recovers after the 8-bit delay in whole seconds, 1..255.
// - a recovery delay of zero disables automatic recovery.
// - charge hot protection trips when the thermistor code is below the hot threshold.
// - hot threshold and release settings are scaled by 54 converter codes per step.
// - charge hot protection releases when the thermistor code is above the hot release level.
// - charge cold protection trips when the thermistor code is above the cold threshold.
// - charge cold protection releases when the thermistor code is below the cold release level.
// - cold threshold and release settings are scaled by 77 converter codes per step.
// - a temperature fault must persist for the set count plus one consecutive measurements to trip; count 0 trips on the first.
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "prot_recovery_map.vh"

module prot_recovery #(
  parameter SEC_CYCLES = `SECOND_NS / `CLK_PERIOD_NS // cycles in one second
) (
  input  wire        aclk,                          // system clock
  input  wire        aresetn,                       // synchronous reset, active low
  input  wire        s_axi_awvalid,                 // write address valid
  output wire        s_axi_awready,                 // write address ready
  input  wire [7:0]  s_axi_awaddr,                  // write byte address
  input  wire        s_axi_wvalid,                  // write data valid
  output wire        s_axi_wready,                  // write data ready
  input  wire [31:0] s_axi_wdata,                   // write data
  input  wire [3:0]  s_axi_wstrb,                   // write byte strobes
  output wire        s_axi_bvalid,                  // write response valid
  input  wire        s_axi_bready,                  // write response ready
  output wire [1:0]  s_axi_bresp,                   // write response
  input  wire        s_axi_arvalid,                 // read address valid
  output wire        s_axi_arready,                 // read address ready
  input  wire [7:0]  s_axi_araddr,                  // read byte address
  output wire        s_axi_rvalid,                  // read data valid
  input  wire        s_axi_rready,                  // read data ready
  output wire [31:0] s_axi_rdata,                   // read data
  output wire [1:0]  s_axi_rresp,                   // read response
  input  wire        short_circuit_discharge_fault, // current fault level
  input  wire        discharge_overcurrent_fault_a, // current fault level
  input  wire        discharge_overcurrent_fault_b, // current fault level
  input  wire        charge_overcurrent_fault,      // current fault level
  input  wire        latch_clear,                   // clears the fet latch
  input  wire        meas_valid,                    // new thermistor sample pulse
  input  wire [15:0] thermistor_sense_input,        // raw thermistor code
  output wire        current_fet_off,               // current protection holds fets off
  output wire        current_latched,               // fets latched off
  output wire        charge_fet_off,                // charge temperature protection active
  output wire        irq                            // unmasked event pending
);

  localparam ST_IDLE  = 4'b0001;
  localparam ST_TRIP  = 4'b0010;
  localparam ST_WATCH = 4'b0100;
  localparam ST_LATCH = 4'b1000;

  // configuration and interrupt registers
  reg  [7:0]           retry_limit_r;
  reg  [7:0]           recovery_secs_r;
  reg  [7:0]           hot_trip_lvl_r;
  reg  [7:0]           hot_trip_cnt_r;
  reg  [7:0]           hot_rel_lvl_r;
  reg  [7:0]           cold_trip_lvl_r;
  reg  [7:0]           cold_trip_cnt_r;
  reg  [7:0]           cold_rel_lvl_r;
  reg  [`IRQ_BITS-1:0] irq_sts_r;
  reg  [`IRQ_BITS-1:0] irq_mask_r;
  reg  [`IRQ_BITS-1:0] irq_sts_nxt;
  reg                  irq_r;

  // bus slave state
  reg                  awready_r;
  reg                  wready_r;
  reg                  bvalid_r;
  reg  [1:0]           bresp_r;
  reg                  arready_r;
  reg                  rvalid_r;
  reg  [31:0]          rdata_r;
  reg  [1:0]           rresp_r;
  reg  [7:0]           waddr_r;
  reg  [31:0]          wdata_r;
  reg                  wlane0_r;
  reg  [31:0]          rd_val;
  reg                  rd_hit;
  reg                  wr_hit;

  // current protection state
  reg  [3:0]           state_r;
  reg  [3:0]           state_nxt;
  reg  [7:0]           rec_tmr_r;
  reg  [7:0]           rec_tmr_nxt;
  reg  [7:0]           watch_r;
  reg  [7:0]           watch_nxt;
  reg  [6:0]           retry_r;
  reg  [6:0]           retry_nxt;
  reg  [6:0]           retry_allow;
  reg                  ev_trip;
  reg                  ev_rec;
  reg                  ev_latch;
  reg                  cur_off_r;
  reg                  cur_latched_r;
  reg                  chg_off_r;
  reg  [31:0]          sec_cnt_r;
  reg                  sec_tick_r;

  wire                 wr_go = ~awready_r & ~wready_r & ~bvalid_r;
  wire                 fault_any = short_circuit_discharge_fault |
                                   discharge_overcurrent_fault_a |
                                   discharge_overcurrent_fault_b |
                                   charge_overcurrent_fault;
  wire [2:0]           retry_code = retry_limit_r[`RETRY_CODE_MSB:`RETRY_CODE_LSB];

  // per channel settings: 0 is hot, 1 is cold
  wire [15:0]          trip_code [0:1];
  wire [15:0]          rel_code  [0:1];
  wire [7:0]           trip_cnt  [0:1];
  wire [1:0]           temp_act;
  wire [1:0]           temp_trip_ev;
  wire [1:0]           temp_rel_ev;

  // threshold scaling into converter codes
  assign trip_code[0] = {8'h00, hot_trip_lvl_r} * `HOT_CODES_PER_STEP;
  assign rel_code[0]  = {8'h00, hot_rel_lvl_r} * `HOT_CODES_PER_STEP;
  assign trip_code[1] = {8'h00, cold_trip_lvl_r} * `COLD_CODES_PER_STEP;
  assign rel_code[1]  = {8'h00, cold_rel_lvl_r} * `COLD_CODES_PER_STEP;
  assign trip_cnt[0]  = hot_trip_cnt_r;
  assign trip_cnt[1]  = cold_trip_cnt_r;

  // one temperature protection per channel
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_temp
      reg  [7:0] persist_r;
      reg        act_r;
      wire       below_trip = thermistor_sense_input < trip_code[ch];
      wire       above_trip = thermistor_sense_input > trip_code[ch];
      wire       below_rel  = thermistor_sense_input < rel_code[ch];
      wire       above_rel  = thermistor_sense_input > rel_code[ch];
      wire       trip_c = (ch == 0) ? below_trip : above_trip;
      wire       rel_c  = (ch == 0) ? above_rel : below_rel;
      wire       enough = persist_r >= trip_cnt[ch];
      assign temp_act[ch]     = act_r;
      assign temp_trip_ev[ch] = meas_valid & ~act_r & trip_c & enough;
      assign temp_rel_ev[ch]  = meas_valid & act_r & rel_c;
      // persistence count advances once per measurement
      always @(posedge aclk) begin
        if (!aresetn) begin
          persist_r <= 8'h00;
          act_r     <= 1'b0;
        end else if (meas_valid) begin
          if (act_r) begin
            persist_r <= 8'h00;
            if (rel_c)
              act_r <= 1'b0;
          end else if (trip_c) begin
            if (enough) begin
              act_r     <= 1'b1;
              persist_r <= 8'h00;
            end else begin
              persist_r <= persist_r + 8'h01;
            end
          end else begin
            persist_r <= 8'h00;
          end
        end
      end
    end
  endgenerate

  // one second tick from the system clock
  always @(posedge aclk) begin
    if (!aresetn) begin
      sec_cnt_r  <= 32'h00000000;
      sec_tick_r <= 1'b0;
    end else if (sec_cnt_r == SEC_CYCLES - 1) begin
      sec_cnt_r  <= 32'h00000000;
      sec_tick_r <= 1'b1;
    end else begin
      sec_cnt_r  <= sec_cnt_r + 32'h00000001;
      sec_tick_r <= 1'b0;
    end
  end

  // decode of the retry limit code
  always @* begin
    case (retry_code)
      3'h1:    retry_allow = 7'h02;
      3'h2:    retry_allow = 7'h04;
      3'h3:    retry_allow = 7'h08;
      3'h4:    retry_allow = 7'h10;
      3'h5:    retry_allow = 7'h20;
      3'h6:    retry_allow = 7'h30;
      3'h7:    retry_allow = 7'h60;
      default: retry_allow = 7'h00;
    endcase
  end

  // current protection trip, recovery and latch sequencing
  always @* begin
    state_nxt   = state_r;
    rec_tmr_nxt = rec_tmr_r;
    watch_nxt   = watch_r;
    retry_nxt   = retry_r;
    ev_trip     = 1'b0;
    ev_rec      = 1'b0;
    ev_latch    = 1'b0;
    case (state_r)
      ST_IDLE, ST_WATCH: begin
        if (fault_any) begin
          if (retry_code != 3'h0 && retry_r >= retry_allow) begin
            state_nxt = ST_LATCH;
            ev_latch  = 1'b1;
          end else begin
            state_nxt   = ST_TRIP;
            rec_tmr_nxt = recovery_secs_r;
            ev_trip     = 1'b1;
          end
        end else if (state_r == ST_WATCH && sec_tick_r) begin
          if (watch_r <= 8'h01) begin
            state_nxt = ST_IDLE;
            retry_nxt = 7'h00;
          end else begin
            watch_nxt = watch_r - 8'h01;
          end
        end
      end
      ST_TRIP: begin
        if (recovery_secs_r != 8'h00 && sec_tick_r) begin
          if (rec_tmr_r <= 8'h01) begin
            state_nxt = ST_WATCH;
            watch_nxt = `WATCH_SECONDS;
            ev_rec    = 1'b1;
            if (retry_r != 7'h7F)
              retry_nxt = retry_r + 7'h01;
          end else begin
            rec_tmr_nxt = rec_tmr_r - 8'h01;
          end
        end
      end
      ST_LATCH: begin
        if (latch_clear) begin
          state_nxt = ST_IDLE;
          retry_nxt = 7'h00;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // protection state and fet outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_r       <= ST_IDLE;
      rec_tmr_r     <= 8'h00;
      watch_r       <= 8'h00;
      retry_r       <= 7'h00;
      cur_off_r     <= 1'b0;
      cur_latched_r <= 1'b0;
      chg_off_r     <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      rec_tmr_r     <= rec_tmr_nxt;
      watch_r       <= watch_nxt;
      retry_r       <= retry_nxt;
      cur_off_r     <= (state_nxt == ST_TRIP) | (state_nxt == ST_LATCH);
      cur_latched_r <= state_nxt == ST_LATCH;
      chg_off_r     <= |temp_act;
    end
  end

  // sticky events, set wins over a write-one clear
  always @* begin
    irq_sts_nxt = irq_sts_r;
    if (wr_go && wlane0_r && waddr_r == `OFS_IRQ_STATUS)
      irq_sts_nxt = irq_sts_r & ~wdata_r[`IRQ_BITS-1:0];
    irq_sts_nxt[`IRQ_CUR_TRIP]     = irq_sts_nxt[`IRQ_CUR_TRIP] | ev_trip;
    irq_sts_nxt[`IRQ_CUR_RECOVER]  = irq_sts_nxt[`IRQ_CUR_RECOVER] | ev_rec;
    irq_sts_nxt[`IRQ_CUR_LATCH]    = irq_sts_nxt[`IRQ_CUR_LATCH] | ev_latch;
    irq_sts_nxt[`IRQ_HOT_TRIP]     = irq_sts_nxt[`IRQ_HOT_TRIP] | temp_trip_ev[0];
    irq_sts_nxt[`IRQ_COLD_TRIP]    = irq_sts_nxt[`IRQ_COLD_TRIP] | temp_trip_ev[1];
    irq_sts_nxt[`IRQ_HOT_RELEASE]  = irq_sts_nxt[`IRQ_HOT_RELEASE] | temp_rel_ev[0];
    irq_sts_nxt[`IRQ_COLD_RELEASE] = irq_sts_nxt[`IRQ_COLD_RELEASE] | temp_rel_ev[1];
  end

  // write address decode
  always @* begin
    case (waddr_r)
      `OFS_RETRY_LIMIT, `OFS_RECOVERY_SECS, `OFS_HOT_TRIP_LVL,
      `OFS_HOT_TRIP_CNT, `OFS_HOT_REL_LVL, `OFS_COLD_TRIP_LVL,
      `OFS_COLD_TRIP_CNT, `OFS_COLD_REL_LVL, `OFS_STATUS,
      `OFS_IRQ_STATUS, `OFS_IRQ_MASK: wr_hit = 1'b1;
      default:                        wr_hit = 1'b0;
    endcase
  end

  // read mux
  always @* begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `OFS_RETRY_LIMIT:   rd_val[7:0] = retry_limit_r;
      `OFS_RECOVERY_SECS: rd_val[7:0] = recovery_secs_r;
      `OFS_HOT_TRIP_LVL:  rd_val[7:0] = hot_trip_lvl_r;
      `OFS_HOT_TRIP_CNT:  rd_val[7:0] = hot_trip_cnt_r;
      `OFS_HOT_REL_LVL:   rd_val[7:0] = hot_rel_lvl_r;
      `OFS_COLD_TRIP_LVL: rd_val[7:0] = cold_trip_lvl_r;
      `OFS_COLD_TRIP_CNT: rd_val[7:0] = cold_trip_cnt_r;
      `OFS_COLD_REL_LVL:  rd_val[7:0] = cold_rel_lvl_r;
      `OFS_STATUS: begin
        rd_val[`ST_TEMP_HOT_BIT]  = temp_act[0];
        rd_val[`ST_TEMP_COLD_BIT] = temp_act[1];
        rd_val[`ST_CUR_TRIP_BIT]  = state_r == ST_TRIP;
        rd_val[`ST_CUR_LATCH_BIT] = state_r == ST_LATCH;
        rd_val[`ST_CUR_WATCH_BIT] = state_r == ST_WATCH;
        rd_val[`ST_RETRY_LSB+6:`ST_RETRY_LSB] = retry_r;
      end
      `OFS_IRQ_STATUS:    rd_val[`IRQ_BITS-1:0] = irq_sts_r;
      `OFS_IRQ_MASK:      rd_val[`IRQ_BITS-1:0] = irq_mask_r;
      default:            rd_hit = 1'b0;
    endcase
  end

  // axi write channel: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= `RESP_OKAY;
      waddr_r   <= 8'h00;
      wdata_r   <= 32'h00000000;
      wlane0_r  <= 1'b0;
    end else begin
      if (awready_r && s_axi_awvalid) begin
        awready_r <= 1'b0;
        waddr_r   <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (wready_r && s_axi_wvalid) begin
        wready_r <= 1'b0;
        wdata_r  <= s_axi_wdata;
        wlane0_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // register file writes and interrupt output
  always @(posedge aclk) begin
    if (!aresetn) begin
      retry_limit_r   <= `RST_RETRY_LIMIT;
      recovery_secs_r <= `RST_RECOVERY_SECS;
      hot_trip_lvl_r  <= `RST_HOT_TRIP_LVL;
      hot_trip_cnt_r  <= `RST_HOT_TRIP_CNT;
      hot_rel_lvl_r   <= `RST_HOT_REL_LVL;
      cold_trip_lvl_r <= `RST_COLD_TRIP_LVL;
      cold_trip_cnt_r <= `RST_COLD_TRIP_CNT;
      cold_rel_lvl_r  <= `RST_COLD_REL_LVL;
      irq_mask_r      <= {`IRQ_BITS{1'b0}};
      irq_sts_r       <= {`IRQ_BITS{1'b0}};
      irq_r           <= 1'b0;
    end else begin
      irq_sts_r <= irq_sts_nxt;
      irq_r     <= |(irq_sts_nxt & irq_mask_r);
      if (wr_go && wlane0_r) begin
        case (waddr_r)
          `OFS_RETRY_LIMIT:   retry_limit_r   <= {5'h00, wdata_r[2:0]};
          `OFS_RECOVERY_SECS: recovery_secs_r <= wdata_r[7:0];
          `OFS_HOT_TRIP_LVL:  hot_trip_lvl_r  <= wdata_r[7:0];
          `OFS_HOT_TRIP_CNT:  hot_trip_cnt_r  <= wdata_r[7:0];
          `OFS_HOT_REL_LVL:   hot_rel_lvl_r   <= wdata_r[7:0];
          `OFS_COLD_TRIP_LVL: cold_trip_lvl_r <= wdata_r[7:0];
          `OFS_COLD_TRIP_CNT: cold_trip_cnt_r <= wdata_r[7:0];
          `OFS_COLD_REL_LVL:  cold_rel_lvl_r  <= wdata_r[7:0];
          `OFS_IRQ_MASK:      irq_mask_r      <= wdata_r[`IRQ_BITS-1:0];
          default:            ;
        endcase
      end
    end
  end

  // axi read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= `RESP_OKAY;
    end else if (arready_r && s_axi_arvalid) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_val;
      rresp_r   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  assign s_axi_awready   = awready_r;
  assign s_axi_wready    = wready_r;
  assign s_axi_bvalid    = bvalid_r;
  assign s_axi_bresp     = bresp_r;
  assign s_axi_arready   = arready_r;
  assign s_axi_rvalid    = rvalid_r;
  assign s_axi_rdata     = rdata_r;
  assign s_axi_rresp     = rresp_r;
  assign current_fet_off = cur_off_r;
  assign current_latched = cur_latched_r;
  assign charge_fet_off  = chg_off_r;
  assign irq             = irq_r;

endmodule

// *** rtl/prot_recovery_map.vh ***
// register map, reset values and timing constants of the protection recovery block
// assumes byte addressing on a 32-bit AXI4-Lite bus, one register per aligned word
`ifndef PROT_RECOVERY_MAP_VH
`define PROT_RECOVERY_MAP_VH

// register byte offsets
`define OFS_RETRY_LIMIT    8'h00
`define OFS_RECOVERY_SECS  8'h04
`define OFS_HOT_TRIP_LVL   8'h08
`define OFS_HOT_TRIP_CNT   8'h0C
`define OFS_HOT_REL_LVL    8'h10
`define OFS_COLD_TRIP_LVL  8'h14
`define OFS_COLD_TRIP_CNT  8'h18
`define OFS_COLD_REL_LVL   8'h1C
`define OFS_STATUS         8'h20
`define OFS_IRQ_STATUS     8'h24
`define OFS_IRQ_MASK       8'h28

// reset values
`define RST_RETRY_LIMIT    8'h00
`define RST_RECOVERY_SECS  8'h05
`define RST_HOT_TRIP_LVL   8'h37
`define RST_HOT_TRIP_CNT   8'h0F
`define RST_HOT_REL_LVL    8'h3F
`define RST_COLD_TRIP_LVL  8'h93
`define RST_COLD_TRIP_CNT  8'h0F
`define RST_COLD_REL_LVL   8'h86

// field positions
`define RETRY_CODE_MSB     2
`define RETRY_CODE_LSB     0
`define ST_TEMP_HOT_BIT    0
`define ST_TEMP_COLD_BIT   1
`define ST_CUR_TRIP_BIT    2
`define ST_CUR_LATCH_BIT   3
`define ST_CUR_WATCH_BIT   4
`define ST_RETRY_LSB       8
`define IRQ_CUR_TRIP       0
`define IRQ_CUR_RECOVER    1
`define IRQ_CUR_LATCH      2
`define IRQ_HOT_TRIP       3
`define IRQ_COLD_TRIP      4
`define IRQ_HOT_RELEASE    5
`define IRQ_COLD_RELEASE   6
`define IRQ_BITS           7

// converter codes per setting step
`define HOT_CODES_PER_STEP  16'd54
`define COLD_CODES_PER_STEP 16'd77

// timing
`define CLK_PERIOD_NS      4
`define SECOND_NS          1000000000
`define WATCH_SECONDS      8'd5

// axi responses
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10

`endif

// *** testbench/prot_recovery_chk.sv ***
// checker: register bus handshake and protection output assertions
// assumes it is bound onto every instance of prot_recovery
`timescale 1ns/100ps
module prot_recovery_chk (
  input wire        aclk,                          // clock
  input wire        aresetn,                       // reset, active low
  input wire        s_axi_awvalid,                 // aw valid
  input wire        s_axi_awready,                 // aw ready
  input wire        s_axi_wvalid,                  // w valid
  input wire        s_axi_wready,                  // w ready
  input wire        s_axi_bvalid,                  // b valid
  input wire        s_axi_bready,                  // b ready
  input wire [1:0]  s_axi_bresp,                   // b response
  input wire        s_axi_arvalid,                 // ar valid
  input wire        s_axi_arready,                 // ar ready
  input wire        s_axi_rvalid,                  // r valid
  input wire        s_axi_rready,                  // r ready
  input wire [31:0] s_axi_rdata,                   // r data
  input wire        short_circuit_discharge_fault, // fault
  input wire        discharge_overcurrent_fault_a, // fault
  input wire        discharge_overcurrent_fault_b, // fault
  input wire        charge_overcurrent_fault,      // fault
  input wire        latch_clear,                   // latch release
  input wire        meas_valid,                    // sample strobe
  input wire        current_fet_off,               // current protection
  input wire        current_latched,               // latch
  input wire        charge_fet_off                 // temperature protection
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire any_fault = short_circuit_discharge_fault | discharge_overcurrent_fault_a |
                   discharge_overcurrent_fault_b | charge_overcurrent_fault;
  // protection outputs
  trip_response_a: assert property (!current_fet_off && any_fault |=> current_fet_off)
    else $error("fault did not disable fets");
  latch_hold_a: assert property (current_latched && !latch_clear |=> current_latched)
    else $error("latch dropped without clear");
  latch_off_a: assert property (current_latched |-> current_fet_off)
    else $error("latched but fets enabled");
  temp_on_meas_a: assert property ($changed(charge_fet_off) |-> $past(meas_valid, 2))
    else $error("charge protection moved without a measurement");
  // register bus
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                                 s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
                                 s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
                                 s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  ready_low_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
endmodule
bind prot_recovery prot_recovery_chk prot_recovery_chk_inst (.*);

// *** testbench/test_prot_recovery.sv ***
// testbench: registers, charge temperature protections, current retry and latch
// assumes a short second through SEC_CYCLES and byte addressed registers
`timescale 1ns/100ps
`include "prot_recovery_map.vh"
module test_prot_recovery;
  localparam SEC = 20;
  reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg         s_axi_arvalid, s_axi_rready, latch_clear, meas_valid;
  reg         short_circuit_discharge_fault, discharge_overcurrent_fault_a;
  reg         discharge_overcurrent_fault_b, charge_overcurrent_fault;
  reg  [7:0]  s_axi_awaddr, s_axi_araddr, lv, cn, rl;
  reg  [31:0] s_axi_wdata, rd;
  reg  [3:0]  s_axi_wstrb;
  reg  [15:0] thermistor_sense_input;
  reg  [1:0]  rs;
  reg  [7:0]  rv [0:7];
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        current_fet_off, current_latched, charge_fet_off, irq;
  integer     mismatches, num_checks, seed, i, n;
  prot_recovery #(.SEC_CYCLES(SEC)) prot_recovery_inst (.*);
  initial begin
    aclk = 0;
    forever #2 aclk = ~aclk;
  end
  task chk(input string nm, input [31:0] s, input [31:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %0s expected %h seen %h", nm, e, s);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // bus cycles: hold each channel until its ready, answer until its valid
  task wr(input [7:0] a, input [31:0] d);
    integer k;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) begin rs = s_axi_bresp; s_axi_bready <= 0; k = 99; end
    end
    if (k != 100) begin mismatches++; summarize; end
  endtask
  task rdr(input [7:0] a);
    integer k;
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) begin rd = s_axi_rdata; rs = s_axi_rresp; s_axi_rready <= 0; k = 99; end
    end
    if (k != 100) begin mismatches++; summarize; end
  endtask
  // one thermistor sample, output settled two edges after the strobe
  task meas(input [15:0] v);
    @(posedge aclk);
    thermistor_sense_input <= v; meas_valid <= 1;
    @(posedge aclk);
    meas_valid <= 0;
    repeat (2) @(posedge aclk);
    #1;
  endtask
  // one-cycle pulse on a randomly chosen current fault line
  task trip;
    @(posedge aclk);
    case ({$random(seed)} % 4)
      0: short_circuit_discharge_fault <= 1;
      1: discharge_overcurrent_fault_a <= 1;
      2: discharge_overcurrent_fault_b <= 1;
      default: charge_overcurrent_fault <= 1;
    endcase
    @(posedge aclk);
    {short_circuit_discharge_fault, discharge_overcurrent_fault_a} <= 2'b00;
    {discharge_overcurrent_fault_b, charge_overcurrent_fault} <= 2'b00;
    #1;
  endtask
  // cycles from trip to automatic recovery, bounded
  task wait_rec;
    for (n = 0; n < 2000 && current_fet_off === 1'b1; n++) begin @(posedge aclk); #1; end
    chk("recovery time", n >= SEC && n <= 2 * SEC + 3, 1);
    if (n == 2000) summarize;
  endtask
  initial begin
    mismatches = 0; num_checks = 0; seed = 32'h6528;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {latch_clear, meas_valid, short_circuit_discharge_fault} = 0;
    {discharge_overcurrent_fault_a, discharge_overcurrent_fault_b} = 0;
    charge_overcurrent_fault = 0; s_axi_awaddr = 0; s_axi_araddr = 0; s_axi_wdata = 0;
    s_axi_wstrb = 4'hF; thermistor_sense_input = 16'hFFFF;
    rv = '{`RST_RETRY_LIMIT, `RST_RECOVERY_SECS, `RST_HOT_TRIP_LVL, `RST_HOT_TRIP_CNT,
           `RST_HOT_REL_LVL, `RST_COLD_TRIP_LVL, `RST_COLD_TRIP_CNT, `RST_COLD_REL_LVL};
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    // reset values, unmapped and read-only places
    for (i = 0; i < 8; i++) begin rdr(i * 4); chk("reset value", rd, rv[i]); end
    rdr(8'h2C); chk("unmapped read", rd, 0); chk("unmapped resp", rs, `RESP_SLVERR);
    wr(8'h2C, 1); chk("unmapped write", rs, `RESP_SLVERR);
    wr(`OFS_STATUS, 32'hFF); rdr(`OFS_STATUS); chk("status ro", rd, 0);
    wr(`OFS_RETRY_LIMIT, 32'hFF); rdr(`OFS_RETRY_LIMIT); chk("retry field", rd, 7);
    wr(`OFS_RETRY_LIMIT, 0);
    // charge hot: strict boundary, persistence, release with hysteresis
    lv = 1 + {$random(seed)} % 200; cn = {$random(seed)} % 4; rl = lv + 1 + {$random(seed)} % 40;
    wr(`OFS_COLD_TRIP_LVL, 8'hFF);
    wr(`OFS_HOT_TRIP_LVL, lv); wr(`OFS_HOT_TRIP_CNT, cn); wr(`OFS_HOT_REL_LVL, rl);
    meas(lv * 54); chk("hot at level", charge_fet_off, 0);
    for (i = 0; i <= cn; i++) begin
      meas(lv * 54 - 1); chk("hot persist", charge_fet_off, i == cn);
    end
    meas(rl * 54); chk("hot hold", charge_fet_off, 1);
    meas(rl * 54 + 1); chk("hot release", charge_fet_off, 0);
    // charge cold: immediate trip, release below its level
    lv = 20 + {$random(seed)} % 200; rl = lv - 1 - {$random(seed)} % 15;
    wr(`OFS_HOT_TRIP_LVL, 0); wr(`OFS_COLD_TRIP_CNT, 0);
    wr(`OFS_COLD_TRIP_LVL, lv); wr(`OFS_COLD_REL_LVL, rl);
    meas(lv * 77); chk("cold at level", charge_fet_off, 0);
    meas(lv * 77 + 1); chk("cold trip", charge_fet_off, 1);
    meas(rl * 77); chk("cold hold", charge_fet_off, 1);
    meas(rl * 77 - 1); chk("cold release", charge_fet_off, 0);
    // retries with latching disabled, then the 5 s quiet clear
    wr(`OFS_RECOVERY_SECS, 2);
    for (i = 0; i < 3; i++) begin
      trip; chk("tripped", current_fet_off, 1);
      wait_rec; chk("no latch", current_latched, 0);
    end
    rdr(`OFS_STATUS); chk("retry count", rd[14:8], 3);
    repeat (6 * SEC + 5) @(posedge aclk);
    rdr(`OFS_STATUS); chk("retry cleared", rd[14:8], 0);
    // code 1 allows two recoveries, then latches; interrupt on latch only
    wr(`OFS_IRQ_MASK, 4); wr(`OFS_RETRY_LIMIT, 1);
    for (i = 0; i < 2; i++) begin trip; wait_rec; end
    chk("irq masked", irq, 0);
    trip; chk("latched", current_latched, 1);
    repeat (2) @(posedge aclk);
    #1 chk("irq latch", irq, 1);
    rdr(`OFS_IRQ_STATUS); chk("irq status", rd, 32'h7F);
    wr(`OFS_IRQ_STATUS, 32'h7F);
    repeat (2) @(posedge aclk);
    #1 chk("irq clear", irq, 0);
    repeat (4 * SEC) @(posedge aclk);
    #1 chk("latch holds", current_fet_off, 1);
    @(posedge aclk) latch_clear <= 1;
    @(posedge aclk) latch_clear <= 0;
    repeat (2) @(posedge aclk);
    #1 chk("latch cleared", {current_latched, current_fet_off}, 0);
    // zero recovery delay never recovers
    wr(`OFS_RECOVERY_SECS, 0);
    trip;
    repeat (10 * SEC) @(posedge aclk);
    #1 chk("no recovery", current_fet_off, 1);
    summarize;
  end
endmodule
